// >>> design/ifd_defs.vh
// Purpose: shared constants of the instruction format decoder
// Assumes: included by every ifd design file by its bare name
// Notes: offsets are byte addresses on the plain register port
`ifndef IFD_DEFS_VH
`define IFD_DEFS_VH
// Register offsets
`define IFD_REG_CTRL 8'h00
`define IFD_REG_STAT 8'h04
`define IFD_REG_TPTR 8'h08
`define IFD_REG_TLAT 8'h0C
`define IFD_REG_ICNT 8'h10
`define IFD_CTRL_RUN 0
`define IFD_CTRL_RST 1'b0
// Instruction cycle phases
`define IFD_PH_FIRST 2'h0
`define IFD_PH_TBL 2'h1
`define IFD_PH_LAST 2'h3
// Field positions
`define IFD_PFX 4'hF
`define IFD_PFX_RNG 15:12
`define IFD_F_RNG 7:0
`define IFD_D_BIT 9
`define IFD_A_BIT 8
`define IFD_B_RNG 11:9
`define IFD_W12_RNG 11:0
`define IFD_N11_RNG 10:0
`define IFD_N8_RNG 7:0
`define IFD_CALL_S_BIT 8
`define IFD_RET_S_BIT 0
`define IFD_IPS_RNG 5:4
`define IFD_KHI_RNG 3:0
`define IFD_TM_RNG 1:0
// Format classes from the opcode lookup
`define IFD_C_OTHER 4'h0
`define IFD_C_BYTE 4'h1
`define IFD_C_BYTE_SKIP 4'h2
`define IFD_C_BIT 4'h3
`define IFD_C_BIT_SKIP 4'h4
`define IFD_C_LIT 4'h5
`define IFD_C_MOVE2 4'h6
`define IFD_C_GOTO2 4'h7
`define IFD_C_CALL2 4'h8
`define IFD_C_LDPTR2 4'h9
`define IFD_C_BRA 4'hA
`define IFD_C_BCOND 4'hB
`define IFD_C_RET 4'hC
`define IFD_C_TBLRD 4'hD
`define IFD_C_TBLWT 4'hE
// Literal widths
`define IFD_LW_8 2'h0
`define IFD_LW_12 2'h1
`define IFD_LW_20 2'h2
// Table pointer modes
`define IFD_TM_KEEP 2'h0
`define IFD_TM_POSTINC 2'h1
`define IFD_TM_POSTDEC 2'h2
`define IFD_TM_PREINC 2'h3
// Reset values
`define IFD_TPTR_RST 21'h000000
`define IFD_TLAT_RST 8'h00
`endif

// >>> design/ifd_phase_gen.v
// Purpose: divides the oscillator clock into four instruction phases
// Assumes: clk_sys is the oscillator clock
// Notes: runs free so phase alignment never depends on software
`timescale 1ns/10ps
`include "ifd_defs.vh"
module ifd_phase_gen (
	input wire clk_sys,
	input wire rst,
	output reg [1:0] phase_ff,
	output wire q_first,
	output wire q_last
);
	// Two-bit counter wraps every four clocks
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			phase_ff <= `IFD_PH_FIRST;
		end else begin
			phase_ff <= phase_ff + 2'h1;
		end
	end

	// Phase strobes
	assign q_first = (phase_ff == `IFD_PH_FIRST);
	assign q_last = (phase_ff == `IFD_PH_LAST);
endmodule

// >>> design/ifd_table_ptr.v
// Purpose: table pointer and table latch with pointer modes
// Assumes: memory read data arrive the cycle after tbl_mem_rd
// Notes: a table operation beats a software pointer write in the same cycle; landing read data beat a latch write
`timescale 1ns/10ps
`include "ifd_defs.vh"
module ifd_table_ptr (
	input wire clk_sys,
	input wire rst,
	input wire op_go,
	input wire op_read,
	input wire [1:0] op_mode,
	input wire sw_ptr_wr,
	input wire sw_lat_wr,
	input wire [20:0] sw_wdata,
	input wire [7:0] tbl_mem_rdata,
	output reg [20:0] ptr_ff,
	output reg [7:0] lat_ff,
	output reg [20:0] tbl_mem_addr,
	output reg tbl_mem_rd,
	output reg tbl_mem_wr
);
	reg rd_pend_ff;
	reg [20:0] nxt_ptr;
	reg [20:0] acc_addr;

	// Access address and pointer update per mode
	always @* begin
		acc_addr = ptr_ff;
		nxt_ptr = ptr_ff;
		case (op_mode)
		`IFD_TM_KEEP: nxt_ptr = ptr_ff;
		`IFD_TM_POSTINC: nxt_ptr = ptr_ff + 21'h000001;
		`IFD_TM_POSTDEC: nxt_ptr = ptr_ff - 21'h000001;
		`IFD_TM_PREINC: begin
			acc_addr = ptr_ff + 21'h000001;
			nxt_ptr = acc_addr;
		end
		default: nxt_ptr = ptr_ff;
		endcase
	end

	// Pointer, latch and memory strobes
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ptr_ff <= `IFD_TPTR_RST;
			lat_ff <= `IFD_TLAT_RST;
			tbl_mem_addr <= `IFD_TPTR_RST;
			tbl_mem_rd <= 1'b0;
			tbl_mem_wr <= 1'b0;
			rd_pend_ff <= 1'b0;
		end else begin
			tbl_mem_rd <= op_go & op_read;
			tbl_mem_wr <= op_go & ~op_read;
			rd_pend_ff <= tbl_mem_rd;
			if (op_go) begin
				tbl_mem_addr <= acc_addr;
				ptr_ff <= nxt_ptr;
			end else if (sw_ptr_wr) begin
				ptr_ff <= sw_wdata;
			end
			// Read data land in the latch one cycle after the strobe
			if (rd_pend_ff) begin
				lat_ff <= tbl_mem_rdata;
			end else if (sw_lat_wr) begin
				lat_ff <= sw_wdata[7:0];
			end
		end
	end
endmodule

// >>> design/ifd_instr_decode.v
// Purpose: splits instruction words into operand fields and paces cycles
// Assumes: fetch_class comes from the opcode lookup with fetch_word
// Notes: fields are raw views; exec_class says which ones matter
`timescale 1ns/10ps
`include "ifd_defs.vh"
module ifd_instr_decode (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire [15:0] fetch_word,
	input wire [3:0] fetch_class,
	output wire fetch_take,
	input wire cond_true,
	input wire [3:0] bank_select_register,
	output wire [1:0] icyc_phase,
	output wire icyc_start,
	output reg exec_valid,
	output reg exec_nop,
	output reg [3:0] exec_class,
	output reg dest_to_file,
	output reg access_ram,
	output reg [3:0] ram_bank,
	output reg [7:0] file_addr,
	output reg [2:0] bit_sel,
	output reg [7:0] bit_mask,
	output reg [19:0] lit_value,
	output reg [1:0] lit_width,
	output reg [1:0] indirect_pointer_sel,
	output reg [11:0] move_source_address,
	output reg [11:0] move_destination_address,
	output reg [19:0] branch_value,
	output reg branch_relative,
	output reg shadow_save,
	output reg shadow_restore,
	output wire [20:0] tbl_mem_addr,
	output wire tbl_mem_rd,
	output wire tbl_mem_wr,
	output wire [7:0] tbl_mem_wdata,
	input wire [7:0] tbl_mem_rdata
);
	// Sequencer states
	localparam ST_FIRST = 2'h0;
	localparam ST_SECOND = 2'h1;
	localparam ST_FLUSH = 2'h2;
	localparam ST_SKIP2 = 2'h3;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg run_ff;
	reg skip_ff;
	reg nxt_skip;
	reg flush_dbl_ff;
	reg [15:0] first_ff;
	reg [1:0] table_pointer_mode_field;
	reg [31:0] icnt_ff;
	reg [31:0] nxt_rdata;
	wire [1:0] phase;
	wire q_first;
	wire q_last;
	wire pfx_word;
	wire tbl_go;
	wire [20:0] program_table_pointer;
	wire [7:0] table_transfer_latch;

	// True for the four classes that span two words
	function is_double;
		input [3:0] cls;
		begin
			is_double = (cls == `IFD_C_MOVE2) |
				(cls == `IFD_C_GOTO2) |
				(cls == `IFD_C_CALL2) |
				(cls == `IFD_C_LDPTR2);
		end
	endfunction

	// True for classes whose outcome rides on the condition input
	function is_cond;
		input [3:0] cls;
		begin
			is_cond = (cls == `IFD_C_BYTE_SKIP) |
				(cls == `IFD_C_BIT_SKIP) |
				(cls == `IFD_C_BCOND);
		end
	endfunction

	// Sign extends an 11-bit or 8-bit offset to 20 bits
	function [19:0] sext;
		input [10:0] v;
		input long;
		begin
			if (long) begin
				sext = {{9{v[10]}}, v};
			end else begin
				sext = {{12{v[7]}}, v[7:0]};
			end
		end
	endfunction

	ifd_phase_gen u_phase (
		.clk_sys(clk_sys),
		.rst(rst),
		.phase_ff(phase),
		.q_first(q_first),
		.q_last(q_last)
	);

	// Words are taken only at the start of a running cycle
	assign icyc_phase = phase;
	assign icyc_start = q_first;
	assign fetch_take = q_first & run_ff;
	assign pfx_word = (fetch_word[`IFD_PFX_RNG] == `IFD_PFX);

	// Table pointer works one phase after the decode lands
	assign tbl_go = (phase == `IFD_PH_TBL) & run_ff & exec_valid &
		((exec_class == `IFD_C_TBLRD) | (exec_class == `IFD_C_TBLWT));
	assign tbl_mem_wdata = table_transfer_latch;

	ifd_table_ptr u_tptr (
		.clk_sys(clk_sys),
		.rst(rst),
		.op_go(tbl_go),
		.op_read(exec_class == `IFD_C_TBLRD),
		.op_mode(table_pointer_mode_field),
		.sw_ptr_wr(reg_wr & (reg_addr == `IFD_REG_TPTR)),
		.sw_lat_wr(reg_wr & (reg_addr == `IFD_REG_TLAT)),
		.sw_wdata(reg_wdata[20:0]),
		.tbl_mem_rdata(tbl_mem_rdata),
		.ptr_ff(program_table_pointer),
		.lat_ff(table_transfer_latch),
		.tbl_mem_addr(tbl_mem_addr),
		.tbl_mem_rd(tbl_mem_rd),
		.tbl_mem_wr(tbl_mem_wr)
	);

	// Field decode at the start of each instruction cycle
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			exec_valid <= 1'b0;
			exec_nop <= 1'b0;
			exec_class <= `IFD_C_OTHER;
			dest_to_file <= 1'b0;
			access_ram <= 1'b0;
			ram_bank <= 4'h0;
			file_addr <= 8'h00;
			bit_sel <= 3'h0;
			bit_mask <= 8'h00;
			lit_value <= 20'h00000;
			lit_width <= `IFD_LW_8;
			indirect_pointer_sel <= 2'h0;
			move_source_address <= 12'h000;
			move_destination_address <= 12'h000;
			branch_value <= 20'h00000;
			branch_relative <= 1'b0;
			shadow_save <= 1'b0;
			shadow_restore <= 1'b0;
			first_ff <= 16'h0000;
			table_pointer_mode_field <= `IFD_TM_KEEP;
			flush_dbl_ff <= 1'b0;
		end else if (q_first) begin
			exec_valid <= 1'b0;
			exec_nop <= 1'b0;
			shadow_save <= 1'b0;
			shadow_restore <= 1'b0;
			if (run_ff) begin
				case (state_ff)
				ST_FIRST: begin
					if (pfx_word) begin
						// Lone second word runs as a no-op
						exec_nop <= 1'b1;
					end else begin
						first_ff <= fetch_word;
						exec_class <= fetch_class;
						// Byte and bit operand views
						file_addr <= fetch_word[`IFD_F_RNG];
						dest_to_file <= fetch_word[`IFD_D_BIT];
						access_ram <= ~fetch_word[`IFD_A_BIT];
						// Bank is forced to zero in access RAM
						ram_bank <= fetch_word[`IFD_A_BIT] ?
							bank_select_register : 4'h0;
						bit_sel <= fetch_word[`IFD_B_RNG];
						bit_mask <= 8'h01 <<
							fetch_word[`IFD_B_RNG];
						// Literal and pointer views
						lit_value <= {12'h000,
							fetch_word[`IFD_F_RNG]};
						lit_width <= `IFD_LW_8;
						indirect_pointer_sel <=
							fetch_word[`IFD_IPS_RNG];
						move_source_address <=
							fetch_word[`IFD_W12_RNG];
						table_pointer_mode_field <=
							fetch_word[`IFD_TM_RNG];
						shadow_restore <=
							(fetch_class == `IFD_C_RET) &
							fetch_word[`IFD_RET_S_BIT];
						// Branch operand view by class
						case (fetch_class)
						`IFD_C_BRA: begin
							branch_value <= sext(
								fetch_word[`IFD_N11_RNG],
								1'b1);
							branch_relative <= 1'b1;
						end
						`IFD_C_BCOND: begin
							branch_value <= sext({3'h0,
								fetch_word[`IFD_N8_RNG]},
								1'b0);
							branch_relative <= 1'b1;
						end
						default: begin
							branch_value <= {12'h000,
								fetch_word[`IFD_N8_RNG]};
							branch_relative <= 1'b0;
						end
						endcase
						// Double-word fields complete next cycle
						exec_valid <= ~is_double(fetch_class);
					end
				end
				ST_SECOND: begin
					exec_valid <= 1'b1;
					move_destination_address <=
						fetch_word[`IFD_W12_RNG];
					case (exec_class)
					`IFD_C_GOTO2, `IFD_C_CALL2: begin
						branch_value <= {fetch_word[`IFD_W12_RNG],
							first_ff[`IFD_N8_RNG]};
						branch_relative <= 1'b0;
						lit_value <= {fetch_word[`IFD_W12_RNG],
							first_ff[`IFD_N8_RNG]};
						lit_width <= `IFD_LW_20;
						shadow_save <=
							(exec_class == `IFD_C_CALL2) &
							first_ff[`IFD_CALL_S_BIT];
					end
					`IFD_C_LDPTR2: begin
						lit_value <= {8'h00,
							first_ff[`IFD_KHI_RNG],
							fetch_word[`IFD_N8_RNG]};
						lit_width <= `IFD_LW_12;
					end
					default: begin
						lit_width <= lit_width;
					end
					endcase
				end
				ST_FLUSH: begin
					// Note whether a skipped word opens a pair
					exec_nop <= 1'b1;
					flush_dbl_ff <= ~pfx_word &
						is_double(fetch_class);
				end
				ST_SKIP2: begin
					exec_nop <= 1'b1;
				end
				default: begin
					exec_nop <= 1'b1;
				end
				endcase
			end
		end
	end

	// Next state chosen once the condition is settled
	always @* begin
		nxt_state = state_ff;
		nxt_skip = skip_ff;
		case (state_ff)
		ST_FIRST: begin
			nxt_state = ST_FIRST;
			nxt_skip = 1'b0;
			if (exec_nop) begin
				nxt_state = ST_FIRST;
			end else if (is_double(exec_class)) begin
				nxt_state = ST_SECOND;
			end else if ((exec_class == `IFD_C_BRA) |
				(exec_class == `IFD_C_RET)) begin
				nxt_state = ST_FLUSH;
			end else if (is_cond(exec_class) & cond_true) begin
				nxt_state = ST_FLUSH;
				nxt_skip = (exec_class != `IFD_C_BCOND);
			end
		end
		ST_SECOND: begin
			nxt_state = ST_FIRST;
		end
		ST_FLUSH: begin
			// A skip over a pair eats its second word too
			if (skip_ff & flush_dbl_ff) begin
				nxt_state = ST_SKIP2;
			end else begin
				nxt_state = ST_FIRST;
			end
			nxt_skip = 1'b0;
		end
		ST_SKIP2: begin
			nxt_state = ST_FIRST;
		end
		default: begin
			nxt_state = ST_FIRST;
		end
		endcase
	end

	// Sequencer and cycle counter advance at the last phase
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff <= ST_FIRST;
			skip_ff <= 1'b0;
			icnt_ff <= 32'h00000000;
		end else if (q_last & run_ff) begin
			state_ff <= nxt_state;
			skip_ff <= nxt_skip;
			icnt_ff <= icnt_ff + 32'h00000001;
		end
	end

	// Control register; clearing run freezes the sequencer in place
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			run_ff <= `IFD_CTRL_RST;
		end else if (reg_wr & (reg_addr == `IFD_REG_CTRL)) begin
			run_ff <= reg_wdata[`IFD_CTRL_RUN];
		end
	end

	// Read mux; unmapped offsets read as zero
	always @* begin
		nxt_rdata = 32'h00000000;
		case (reg_addr)
		`IFD_REG_CTRL: nxt_rdata = {31'h00000000, run_ff};
		`IFD_REG_STAT: nxt_rdata = {24'h000000, flush_dbl_ff,
			skip_ff, exec_nop, exec_valid, phase, state_ff};
		`IFD_REG_TPTR: nxt_rdata = {11'h000, program_table_pointer};
		`IFD_REG_TLAT: nxt_rdata = {24'h000000, table_transfer_latch};
		`IFD_REG_ICNT: nxt_rdata = icnt_ff;
		default: nxt_rdata = 32'h00000000;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= nxt_rdata;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule

// >>> dv/ifd_instr_decode_checker.sv
// Purpose: port-level timing and field checks for the decoder
// Assumes: bound to ifd_instr_decode; one clock, async reset
// Notes: field checks look at phase 1, right after the word is taken
`timescale 1ns/10ps
`include "ifd_defs.vh"
module ifd_instr_decode_checker (
	input wire clk_sys,
	input wire rst,
	input wire [15:0] fetch_word,
	input wire fetch_take,
	input wire [3:0] bank_select_register,
	input wire [1:0] icyc_phase,
	input wire icyc_start,
	input wire exec_valid,
	input wire exec_nop,
	input wire [3:0] exec_class,
	input wire dest_to_file,
	input wire access_ram,
	input wire [3:0] ram_bank,
	input wire [7:0] file_addr,
	input wire [2:0] bit_sel,
	input wire [7:0] bit_mask,
	input wire [11:0] move_destination_address,
	input wire [19:0] branch_value,
	input wire shadow_save,
	input wire shadow_restore,
	input wire tbl_mem_rd,
	input wire tbl_mem_wr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Live decode just after a take; flushed cycles are left out
	wire p1 = icyc_phase == 2'h1 && exec_valid && !exec_nop;

	chk_take_phase: assert property (fetch_take |-> icyc_phase == 2'h0)
		else $error("word taken outside phase 0");
	chk_phase_ring: assert property (icyc_start |=> !icyc_start [*3] ##1 icyc_start)
		else $error("instruction cycle is not four clocks");
	chk_byte_fields: assert property (p1 && exec_class == `IFD_C_BYTE |->
		dest_to_file == $past(fetch_word[9]) && file_addr == $past(fetch_word[7:0]))
		else $error("byte operand fields wrong");
	chk_bank_select: assert property (p1 && exec_class == `IFD_C_BYTE |->
		access_ram == !$past(fetch_word[8]) && ram_bank ==
		($past(fetch_word[8]) ? $past(bank_select_register) : 4'h0))
		else $error("bank selection wrong");
	chk_bit_mask: assert property (p1 && exec_class == `IFD_C_BIT |->
		bit_sel == $past(fetch_word[11:9]) &&
		bit_mask == (8'h01 << $past(fetch_word[11:9])))
		else $error("bit select or mask wrong");
	chk_move_dest: assert property (p1 && exec_class == `IFD_C_MOVE2 |->
		move_destination_address == $past(fetch_word[11:0]))
		else $error("move destination wrong");
	chk_double_len: assert property (p1 && exec_class == `IFD_C_MOVE2 |->
		!$past(exec_valid, 4) && !$past(exec_nop, 4))
		else $error("double word not two cycles");
	chk_abs_target: assert property (p1 && exec_class == `IFD_C_GOTO2 |->
		branch_value == {$past(fetch_word[11:0]), $past(fetch_word[7:0], 5)})
		else $error("absolute target wrong");
	chk_flush_bra: assert property (p1 && exec_class == `IFD_C_BRA |=> ##3 exec_nop)
		else $error("no flush after branch");
	chk_ret_shadow: assert property (p1 && exec_class == `IFD_C_RET |->
		shadow_restore == $past(fetch_word[0]))
		else $error("fast return flag wrong");
	chk_tbl_strobe: assert property (p1 && exec_class == `IFD_C_TBLRD |-> ##[1:2] tbl_mem_rd)
		else $error("table read not issued");
	chk_rd_pulse: assert property (tbl_mem_rd |=> !tbl_mem_rd)
		else $error("table read strobe too long");

	cov_move: cover property (p1 && exec_class == `IFD_C_MOVE2);
	cov_save: cover property (shadow_save);
	cov_twr: cover property (tbl_mem_wr);
endmodule
bind ifd_instr_decode ifd_instr_decode_checker ifd_instr_decode_checker_i (.*);

// >>> dv/ifd_tbl_mem_model.sv
// Purpose: program memory seen by table reads and writes
// Assumes: read data are wanted one clock after the read strobe
// Notes: keeps the last address and write byte for the bench
`timescale 1ns/10ps
module ifd_tbl_mem_model (
	input wire clk_sys,
	input wire rst,
	input wire [20:0] tbl_mem_addr,
	input wire tbl_mem_rd,
	input wire tbl_mem_wr,
	input wire [7:0] tbl_mem_wdata,
	output logic [7:0] tbl_mem_rdata,
	output logic [20:0] seen_addr,
	output logic [7:0] seen_wdata
);
	// Data only hold for one clock; toggling after that catches a late load
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tbl_mem_rdata <= 8'h00;
			seen_addr <= 21'h000000;
			seen_wdata <= 8'h00;
		end else begin
			tbl_mem_rdata <= tbl_mem_rd ? ~tbl_mem_addr[7:0] : ~tbl_mem_rdata;
			if (tbl_mem_rd || tbl_mem_wr)
				seen_addr <= tbl_mem_addr;
			if (tbl_mem_wr)
				seen_wdata <= tbl_mem_wdata;
		end
	end
endmodule

// >>> dv/instruction_format_decode_tb_top.sv
// Purpose: self-checking bench for the instruction format decoder
// Assumes: bank select held at 5 throughout
// Notes: a filler word follows each case of the rows table to see whether it is flushed
`timescale 1ns/10ps
`include "ifd_defs.vh"
module instruction_format_decode_tb_top;
	typedef struct packed {logic [15:0] w; logic [3:0] c; logic t; logic n;
		logic [23:0] e;} ifd_row_t;
	logic clk_sys, rst, reg_wr, reg_rd, cond_true;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, rd;
	logic [15:0] fetch_word;
	logic [3:0] fetch_class, bank_select_register;
	logic [20:0] p, a;
	wire [31:0] reg_rdata;
	wire fetch_take, icyc_start, exec_valid, exec_nop, dest_to_file, access_ram;
	wire branch_relative, shadow_save, shadow_restore, tbl_mem_rd, tbl_mem_wr;
	wire [1:0] icyc_phase, lit_width, indirect_pointer_sel;
	wire [3:0] exec_class, ram_bank;
	wire [7:0] file_addr, bit_mask, tbl_mem_wdata, tbl_mem_rdata, seen_wdata;
	wire [2:0] bit_sel;
	wire [19:0] lit_value, branch_value;
	wire [11:0] move_source_address, move_destination_address;
	wire [20:0] tbl_mem_addr, seen_addr;
	int num_errors, n_checks, i;
	ifd_row_t rows[13] = '{
		'{16'h27A5, `IFD_C_BYTE, 1'b0, 1'b0, 24'h0025A5},
		'{16'h2432, `IFD_C_BYTE, 1'b0, 1'b0, 24'h001032},
		'{16'h6201, `IFD_C_BYTE_SKIP, 1'b0, 1'b0, 24'h003001},
		'{16'h8E0F, `IFD_C_BIT, 1'b0, 1'b0, 24'h07800F},
		'{16'hB301, `IFD_C_BIT_SKIP, 1'b0, 1'b0, 24'h010201},
		'{16'h0E7F, `IFD_C_LIT, 1'b0, 1'b0, 24'h00007F},
		'{16'hD7FF, `IFD_C_BRA, 1'b0, 1'b1, 24'h1FFFFF},
		'{16'hE205, `IFD_C_BCOND, 1'b1, 1'b1, 24'h100005},
		'{16'hE2FB, `IFD_C_BCOND, 1'b0, 1'b0, 24'h1FFFFB},
		'{16'h0013, `IFD_C_RET, 1'b0, 1'b1, 24'h000001},
		'{16'h0012, `IFD_C_RET, 1'b0, 1'b1, 24'h000000},
		'{16'h6201, `IFD_C_BYTE_SKIP, 1'b1, 1'b1, 24'h003001},
		'{16'hB301, `IFD_C_BIT_SKIP, 1'b1, 1'b1, 24'h010201}};

	ifd_instr_decode ifd_instr_decode_i (.*);
	ifd_tbl_mem_model ifd_tbl_mem_model_i (.*);

	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Register port: one-cycle strobes, read data the cycle after
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] ad);
		@(posedge clk_sys);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask
	// Offer one word for the next take, then park a no-op behind it
	task automatic cyc(input logic [15:0] w, input logic [3:0] c, input logic t);
		int k;
		k = 0;
		// Step off the edge so the phase is read after it settles
		#1;
		while (icyc_phase !== 2'h3 && k < 8) begin
			@(posedge clk_sys);
			#1 k++;
		end
		if (k == 8) begin
			num_errors++;
			conclude();
		end
		@(posedge clk_sys);
		fetch_word <= w;
		fetch_class <= c;
		cond_true <= t;
		@(posedge clk_sys);
		fetch_word <= 16'h0000;
		fetch_class <= `IFD_C_OTHER;
		#1;
	endtask
	task automatic dw(input logic [15:0] w1, input logic [15:0] w2, input logic [3:0] c);
		cyc(w1, c, 1'b0);
		chk("first word", 32'h0, {30'h0, exec_valid, exec_nop});
		cyc(w2, `IFD_C_OTHER, 1'b0);
		chk("second word", 32'h2, {30'h0, exec_valid, exec_nop});
	endtask
	function automatic logic [23:0] probe(input logic [3:0] c);
		case (c)
			`IFD_C_BIT, `IFD_C_BIT_SKIP: probe = {5'h00, bit_sel, bit_mask, file_addr};
			`IFD_C_LIT: probe = {2'h0, lit_width, lit_value};
			`IFD_C_BRA, `IFD_C_BCOND: probe = {3'h0, branch_relative, branch_value};
			`IFD_C_RET: probe = {23'h000000, shadow_restore};
			default: probe = {10'h000, dest_to_file, access_ram, ram_bank, file_addr};
		endcase
	endfunction

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, cond_true} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		fetch_word = 16'h0000;
		fetch_class = `IFD_C_OTHER;
		bank_select_register = 4'h5;
		num_errors = 0;
		n_checks = 0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rdr(`IFD_REG_TPTR);
		chk("pointer reset", 32'h0, rd);
		rdr(`IFD_REG_TLAT);
		chk("latch reset", 32'h0, rd);
		rdr(8'h14);
		chk("unmapped", 32'h0, rd);
		wr(`IFD_REG_CTRL, 32'h1);
		foreach (rows[r]) begin
			cyc(rows[r].w, rows[r].c, rows[r].t);
			chk("live", 32'h2, {30'h0, exec_valid, exec_nop});
			chk("fields", {4'h0, rows[r].c, rows[r].e}, {4'h0, exec_class, probe(rows[r].c)});
			cyc(16'h0E00, `IFD_C_LIT, 1'b0);
			chk("flush", {31'h0, rows[r].n}, {31'h0, exec_nop});
		end
		dw(16'hC123, 16'hF456, `IFD_C_MOVE2);
		chk("move", 32'h00123456, {8'h00, move_source_address, move_destination_address});
		dw(16'hEF9A, 16'hF345, `IFD_C_GOTO2);
		chk("goto", 32'h0023459A, {10'h000, lit_width, lit_value});
		chk("goto rel", 32'h0, {31'h0, branch_relative});
		dw(16'hED12, 16'hFABC, `IFD_C_CALL2);
		chk("fast call", 32'h1, {31'h0, shadow_save});
		dw(16'hEE2A, 16'hF0BC, `IFD_C_LDPTR2);
		chk("ptr load", 32'h00900ABC, {8'h00, indirect_pointer_sel, lit_width, lit_value});
		// Skip over a two-word move burns both of its words
		cyc(16'h6201, `IFD_C_BYTE_SKIP, 1'b1);
		cyc(16'hC123, `IFD_C_MOVE2, 1'b0);
		chk("skip w1", 32'h1, {31'h0, exec_nop});
		cyc(16'hF456, `IFD_C_OTHER, 1'b0);
		chk("skip w2", 32'h1, {31'h0, exec_nop});
		cyc(16'hF123, `IFD_C_OTHER, 1'b0);
		chk("lone prefix", 32'h1, {31'h0, exec_nop});
		// Every table pointer mode, starting near the top of the space
		wr(`IFD_REG_TPTR, 32'hFFFFFFF0);
		p = 21'h1FFFF0;
		for (i = 0; i < 4; i++) begin
			a = (i == 3) ? p + 21'h1 : p;
			p = (i == 2) ? p - 21'h1 : ((i == 0) ? p : p + 21'h1);
			cyc({14'h0002, i[1:0]}, `IFD_C_TBLRD, 1'b0);
			cyc(16'h0000, `IFD_C_OTHER, 1'b0);
			chk("table addr", {11'h000, a}, {11'h000, seen_addr});
			rdr(`IFD_REG_TPTR);
			chk("pointer", {11'h000, p}, rd);
			rdr(`IFD_REG_TLAT);
			chk("latch", {24'h000000, ~a[7:0]}, rd);
		end
		wr(`IFD_REG_TLAT, 32'hFFFFFF5A);
		cyc(16'h000C, `IFD_C_TBLWT, 1'b0);
		cyc(16'h0000, `IFD_C_OTHER, 1'b0);
		chk("table write", 32'h5A, {24'h000000, seen_wdata});
		// Clearing run must stop takes; a live word would show as valid
		wr(`IFD_REG_CTRL, 32'h0);
		rdr(`IFD_REG_CTRL);
		chk("run off", 32'h0, rd);
		cyc(16'h0E55, `IFD_C_LIT, 1'b0);
		chk("stopped", 32'h0, {30'h0, exec_valid, exec_nop});
		conclude();
	end
endmodule
